/* verilog/kse_pkg.sv */
// Constants, codes and carrier types of the keypad setting editor.
// Shared by the editor core and by whoever binds to its ports.
package kse_pkg;
   localparam int CLK_HZ = 100_000_000;
   localparam int DEBOUNCE_MS = 10;
   localparam int DEBOUNCE_CYC = DEBOUNCE_MS * (CLK_HZ / 1000);
   localparam int PULSE_S = 2;
   localparam int PULSE_CYC = PULSE_S * CLK_HZ;
   localparam int DEB_W = 20;
   localparam int PULSE_W = 28;
   localparam int NUM_KEYS = 11;
   localparam int K_SEC = 0;
   localparam int K_PRI = 1;
   localparam int K_DEV = 2;
   localparam int K_COMP = 3;
   localparam int K_NOM = 4;
   localparam int K_SCALE = 5;
   localparam int K_DIGIT = 6;
   localparam int K_INC = 7;
   localparam int K_SAVE = 8;
   localparam int K_SIGN = 9;
   localparam int K_MODE = 10;
   localparam logic [2:0] VW_SEC = 3'h0;
   localparam logic [2:0] VW_PRI = 3'h1;
   localparam logic [2:0] VW_DEV = 3'h2;
   localparam logic [2:0] VW_COMP = 3'h3;
   localparam logic [2:0] VW_NOM = 3'h4;
   localparam logic [2:0] VW_SCALE = 3'h5;
   localparam logic [1:0] GL_NONE = 2'h0;
   localparam logic [1:0] GL_POS = 2'h1;
   localparam logic [1:0] GL_NEG = 2'h2;
   localparam logic [1:0] GL_ABSENT = 2'h3;
   localparam logic [1:0] SEL_NOM = 2'h0;
   localparam logic [1:0] SEL_SCALE = 2'h1;
   localparam logic [1:0] SEL_COMP = 2'h2;
   localparam logic [3:0] REG_STATUS = 4'h0;
   localparam logic [3:0] REG_MASK = 4'h4;
   localparam logic [3:0] REG_STATE = 4'h8;
   localparam int NUM_EVT = 3;
   localparam int EV_SAVED = 0;
   localparam int EV_REJECT = 1;
   localparam int EV_MODE = 2;
   localparam logic [15:0] NOM_RST = 16'h1100;
   localparam logic [15:0] SCALE_RST = 16'h0220;
   localparam logic [15:0] COMP_RST = 16'h0000;
   localparam logic [15:0] COMP_MAX = 16'h00C8;
   localparam logic [15:0] NOM_MIN = 16'h0352;
   localparam logic [15:0] NOM_MAX = 16'h0578;
   localparam logic [15:0] SCALE_MAX = 16'h270F;
   localparam logic [31:0] DEV_SCALE = 32'h0000_03E8;
   localparam logic [5:0] DIV_STEPS = 6'h20;
   localparam logic [1:0] CUR_MSD = 2'h3;

   typedef enum logic [1:0] {
      ED_VIEW = 2'b01,
      ED_EDIT = 2'b10
   } kse_ed_t;

   typedef struct packed {
      logic [3:0] addr;
      logic [31:0] wdata;
      logic we;
      logic re;
   } kse_bus_t;

   typedef struct packed {
      logic [15:0] value;
      logic bcd;
      logic [3:0] blink;
      logic [1:0] glyph;
      logic indVolt;
      logic indKv;
      logic indPct;
      logic indMode;
   } kse_disp_t;

   typedef struct packed {
      logic raise;
      logic lower;
      logic underVolt;
      logic highVolt;
      logic ctrlFail;
   } kse_relay_t;

   typedef struct packed {
      logic write;
      logic [1:0] sel;
      logic [15:0] data;
      logic sign;
   } kse_nv_t;
endpackage

/* verilog/kse_keypad_editor.sv */
// Front-panel keypad editor: views, digit editing, save, auto/manual relays.
// Keys and the option pin are asynchronous; measurement, regulation
// requests and alarms arrive on clk_sys. Store writes are fire-and-forget.
//
// Contract
// - Compensation accepted only 0 to 20 percent; percent lamp while shown.
// - Compensation shows plus or minus glyph, or absent glyph without option.
// - Mode key toggles mode; in auto, raise/lower requests drive relays.
// - Manual mode holds raise and lower relays off.
// - Alarm relays work in both modes; voltage viewable in both.
// - Mode lamp on in manual, off in auto.
// - Digit key ignored unless a setting shown; first press blinks MSD.
// - Further digit presses move cursor one digit toward LSD.
// - After the LSD the cursor wraps back to the MSD.
// - Increment raises blinking digit, 0 to 9; no effect on glyphs.
// - Leaving an edit without save keeps the stored value.
// - Save out of limits stores nothing, stays editing, MSD blinking.
// - Save of an edited value within limits writes the store, then shows secondary voltage.
// - Primary view shows secondary times scale over nominal; kV lamp.
// - Secondary view shows measured voltage; volts lamp.
// - Deviation view shows percent from nominal with sign glyph; percent lamp.
// - Raise/lower relays pulse 2 s; alarm relays follow their condition.
// - Sign key toggles compensation sign only while shown; saved on save.
`timescale 1ns/100ps
`default_nettype none
module kse_keypad_editor #(
   parameter int DEB_CYC = kse_pkg::DEBOUNCE_CYC,
   parameter int PULSE_CYC_P = kse_pkg::PULSE_CYC
) (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic [kse_pkg::NUM_KEYS-1:0] keyPin,
   input wire logic optionPin,
   input wire logic [15:0] secVolt,
   input wire logic raiseReq,
   input wire logic lowerReq,
   input wire logic underVoltIn,
   input wire logic highVoltIn,
   input wire logic ctrlFailIn,
   input wire kse_pkg::kse_bus_t bus,
   output logic [31:0] rdata,
   output logic irq,
   output kse_pkg::kse_disp_t disp,
   output kse_pkg::kse_relay_t relay,
   output kse_pkg::kse_nv_t nvStore
);
   import kse_pkg::*;

   typedef struct packed {
      logic [NUM_KEYS-1:0] keySync1;
      logic [NUM_KEYS-1:0] keySync2;
      logic [NUM_KEYS-1:0] keyDb;
      logic [NUM_KEYS-1:0] keyDbPrev;
      logic [NUM_KEYS-1:0][DEB_W-1:0] debCnt;
      logic [1:0] optSync;
      kse_ed_t edState;
      logic [2:0] view;
      logic [1:0] cursor;
      logic [15:0] editVal;
      logic editSign;
      logic edited;
      logic [15:0] nomSet;
      logic [15:0] scaleSet;
      logic [15:0] compSet;
      logic compSign;
      logic autoMode;
      logic [PULSE_W-1:0] raiseCnt;
      logic [PULSE_W-1:0] lowerCnt;
      logic [31:0] divNum;
      logic [15:0] divDen;
      logic [16:0] divRem;
      logic [31:0] divQuo;
      logic [5:0] divCnt;
      logic divPos;
      logic divNeg;
      logic [15:0] calcVal;
      logic devPos;
      logic devNeg;
      logic [NUM_EVT-1:0] status;
      logic [NUM_EVT-1:0] mask;
      logic [31:0] rdata;
      logic irq;
      kse_disp_t disp;
      kse_relay_t relay;
      kse_nv_t nv;
   } kse_core_t;

   kse_core_t s_r;
   kse_core_t s_nxt;
   logic [NUM_KEYS-1:0] press;

   function automatic logic [15:0] bcd2bin(input logic [15:0] v);
      bcd2bin = 16'(v[15:12]) * 16'h03E8 + 16'(v[11:8]) * 16'h0064
         + 16'(v[7:4]) * 16'h000A + 16'(v[3:0]);
   endfunction

   function automatic logic editable(input logic [2:0] vw,
      input logic opt);
      editable = (vw == VW_NOM) || (vw == VW_SCALE)
         || ((vw == VW_COMP) && opt);
   endfunction

   function automatic logic limitOk(input logic [2:0] vw,
      input logic [15:0] v);
      logic [15:0] b;
      b = bcd2bin(v);
      case (vw)
         VW_NOM: limitOk = (b >= NOM_MIN) && (b <= NOM_MAX);
         VW_COMP: limitOk = (b <= COMP_MAX);
         default: limitOk = (b <= SCALE_MAX);
      endcase
   endfunction

   assign press = s_r.keyDb & ~s_r.keyDbPrev;

   always_comb begin
      logic [15:0] nomBin;
      logic [15:0] diff;
      logic [16:0] trial;
      logic [3:0] dig;
      logic rdStatus;
      s_nxt = s_r;
      nomBin = bcd2bin(s_r.nomSet);
      diff = 16'h0000;
      trial = 17'h00000;
      dig = 4'h0;
      rdStatus = 1'b0;
      s_nxt.keySync1 = keyPin;
      s_nxt.keySync2 = s_r.keySync1;
      s_nxt.keyDbPrev = s_r.keyDb;
      s_nxt.optSync = {s_r.optSync[0], optionPin};
      s_nxt.nv.write = 1'b0;
      for (int k = 0; k < NUM_KEYS; k++) begin
         if (s_r.keySync2[k] == s_r.keyDb[k]) begin
            s_nxt.debCnt[k] = '0;
         end else if (s_r.debCnt[k] == DEB_W'(DEB_CYC - 1)) begin
            s_nxt.debCnt[k] = '0;
            s_nxt.keyDb[k] = s_r.keySync2[k];
         end else begin
            s_nxt.debCnt[k] = s_r.debCnt[k] + 1'b1;
         end
      end
      if (press[K_MODE]) begin
         s_nxt.autoMode = ~s_r.autoMode;
      end
      if (|press[K_SCALE:K_SEC]) begin
         s_nxt.edState = ED_VIEW;
         s_nxt.edited = 1'b0;
         for (int k = 0; k <= K_SCALE; k++) begin
            if (press[k]) begin
               s_nxt.view = 3'(k);
            end
         end
      end else begin
         case (s_r.edState)
            ED_VIEW: begin
               if (press[K_DIGIT] && editable(s_r.view, s_r.optSync[1])) begin
                  s_nxt.edState = ED_EDIT;
                  s_nxt.cursor = CUR_MSD;
                  s_nxt.edited = 1'b0;
                  s_nxt.editSign = s_r.compSign;
                  s_nxt.editVal = (s_r.view == VW_NOM) ? s_r.nomSet
                     : (s_r.view == VW_SCALE) ? s_r.scaleSet : s_r.compSet;
               end else if (press[K_SIGN] && (s_r.view == VW_COMP)
                  && s_r.optSync[1]) begin
                  // sign toggled into a pending edit
                  s_nxt.edState = ED_EDIT;
                  s_nxt.cursor = CUR_MSD;
                  s_nxt.edited = 1'b1;
                  s_nxt.editSign = ~s_r.compSign;
                  s_nxt.editVal = s_r.compSet;
               end
            end
            ED_EDIT: begin
               if (press[K_DIGIT]) begin
                  s_nxt.cursor = s_r.cursor - 2'h1;
               end else if (press[K_INC]) begin
                  dig = s_r.editVal[s_r.cursor*4 +: 4];
                  s_nxt.editVal[s_r.cursor*4 +: 4] =
                     (dig >= 4'h9) ? 4'h0 : dig + 4'h1;
                  s_nxt.edited = 1'b1;
               end else if (press[K_SIGN] && (s_r.view == VW_COMP)) begin
                  s_nxt.editSign = ~s_r.editSign;
                  s_nxt.edited = 1'b1;
               end else if (press[K_SAVE]) begin
                  if (!s_r.edited) begin
                     s_nxt.edState = ED_VIEW;
                  end else if (limitOk(s_r.view, s_r.editVal)) begin
                     s_nxt.nv.write = 1'b1;
                     s_nxt.nv.data = s_r.editVal;
                     s_nxt.nv.sign = s_r.editSign;
                     s_nxt.edState = ED_VIEW;
                     s_nxt.edited = 1'b0;
                     s_nxt.view = VW_SEC;
                     case (s_r.view)
                        VW_NOM: begin
                           s_nxt.nomSet = s_r.editVal;
                           s_nxt.nv.sel = SEL_NOM;
                        end
                        VW_SCALE: begin
                           s_nxt.scaleSet = s_r.editVal;
                           s_nxt.nv.sel = SEL_SCALE;
                        end
                        default: begin
                           s_nxt.compSet = s_r.editVal;
                           s_nxt.compSign = s_r.editSign;
                           s_nxt.nv.sel = SEL_COMP;
                        end
                     endcase
                  end else begin
                     s_nxt.cursor = CUR_MSD;
                  end
               end
            end
            default: s_nxt.edState = ED_VIEW;
         endcase
      end
      // next mode, so manual drops a pulse at once
      if (!s_nxt.autoMode) begin
         s_nxt.raiseCnt = '0;
         s_nxt.lowerCnt = '0;
      end else begin
         if (s_r.raiseCnt != '0) begin
            s_nxt.raiseCnt = s_r.raiseCnt - 1'b1;
         end else if (raiseReq) begin
            s_nxt.raiseCnt = PULSE_W'(PULSE_CYC_P);
         end
         if (s_r.lowerCnt != '0) begin
            s_nxt.lowerCnt = s_r.lowerCnt - 1'b1;
         end else if (lowerReq) begin
            s_nxt.lowerCnt = PULSE_W'(PULSE_CYC_P);
         end
      end
      s_nxt.relay.raise = (s_nxt.raiseCnt != '0);
      s_nxt.relay.lower = (s_nxt.lowerCnt != '0);
      // alarms follow their condition in any mode
      s_nxt.relay.underVolt = underVoltIn;
      s_nxt.relay.highVolt = highVoltIn;
      s_nxt.relay.ctrlFail = ctrlFailIn;
      // Shared serial divider; a view switch shows a stale figure briefly
      if (s_r.divCnt == '0) begin
         if (secVolt >= nomBin) begin
            diff = secVolt - nomBin;
         end else begin
            diff = nomBin - secVolt;
         end
         s_nxt.divNum = (s_r.view == VW_DEV) ? 32'(diff) * DEV_SCALE
            : 32'(secVolt) * 32'(bcd2bin(s_r.scaleSet));
         s_nxt.divDen = nomBin;
         s_nxt.divRem = '0;
         s_nxt.divQuo = '0;
         s_nxt.divPos = secVolt > nomBin;
         s_nxt.divNeg = secVolt < nomBin;
         s_nxt.divCnt = DIV_STEPS;
      end else begin
         trial = {s_r.divRem[15:0], s_r.divNum[31]};
         s_nxt.divNum = {s_r.divNum[30:0], 1'b0};
         if (trial >= {1'b0, s_r.divDen}) begin
            s_nxt.divRem = trial - {1'b0, s_r.divDen};
            s_nxt.divQuo = {s_r.divQuo[30:0], 1'b1};
         end else begin
            s_nxt.divRem = trial;
            s_nxt.divQuo = {s_r.divQuo[30:0], 1'b0};
         end
         s_nxt.divCnt = s_r.divCnt - 6'h01;
         if (s_r.divCnt == 6'h01) begin
            s_nxt.calcVal = (s_nxt.divQuo[31:16] != '0) ? 16'hFFFF
               : s_nxt.divQuo[15:0];
            s_nxt.devPos = s_r.divPos;
            s_nxt.devNeg = s_r.divNeg;
         end
      end
      // Display image from the next state
      s_nxt.disp = '0;
      s_nxt.disp.indMode = ~s_nxt.autoMode;
      case (s_nxt.view)
         VW_PRI: begin
            s_nxt.disp.value = s_nxt.calcVal;
            s_nxt.disp.indKv = 1'b1;
         end
         VW_DEV: begin
            s_nxt.disp.value = s_nxt.calcVal;
            s_nxt.disp.indPct = 1'b1;
            s_nxt.disp.glyph = s_nxt.devPos ? GL_POS
               : s_nxt.devNeg ? GL_NEG : GL_NONE;
         end
         VW_COMP: begin
            // percent lamp, sign or absent glyph
            s_nxt.disp.indPct = 1'b1;
            s_nxt.disp.bcd = 1'b1;
            s_nxt.disp.value = s_nxt.compSet;
            s_nxt.disp.glyph = !s_r.optSync[1] ? GL_ABSENT
               : (s_nxt.edState == ED_EDIT ? s_nxt.editSign
               : s_nxt.compSign) ? GL_NEG : GL_POS;
         end
         VW_NOM: begin
            s_nxt.disp.indVolt = 1'b1;
            s_nxt.disp.bcd = 1'b1;
            s_nxt.disp.value = s_nxt.nomSet;
         end
         VW_SCALE: begin
            s_nxt.disp.indKv = 1'b1;
            s_nxt.disp.bcd = 1'b1;
            s_nxt.disp.value = s_nxt.scaleSet;
         end
         default: begin
            s_nxt.disp.value = secVolt;
            s_nxt.disp.indVolt = 1'b1;
         end
      endcase
      if (s_nxt.edState == ED_EDIT) begin
         s_nxt.disp.value = s_nxt.editVal;
         s_nxt.disp.blink = 4'h1 << s_nxt.cursor;
      end
      // Register port; set beats the read-clear
      rdStatus = bus.re && (bus.addr == REG_STATUS);
      s_nxt.rdata = '0;
      if (bus.re) begin
         case (bus.addr)
            REG_STATUS: s_nxt.rdata = 32'(s_r.status);
            REG_MASK: s_nxt.rdata = 32'(s_r.mask);
            REG_STATE: s_nxt.rdata = {24'h000000, s_r.autoMode,
               s_r.view, s_r.cursor, s_r.edState};
            default: s_nxt.rdata = '0;
         endcase
      end
      if (bus.we && (bus.addr == REG_MASK)) begin
         s_nxt.mask = bus.wdata[NUM_EVT-1:0];
      end
      s_nxt.status = rdStatus ? '0 : s_r.status;
      s_nxt.status[EV_SAVED] = s_nxt.status[EV_SAVED] | s_nxt.nv.write;
      s_nxt.status[EV_REJECT] = s_nxt.status[EV_REJECT]
         | (s_r.edState == ED_EDIT && press[K_SAVE] && s_r.edited
         && !s_nxt.nv.write && !(|press[K_SCALE:K_SEC]));
      s_nxt.status[EV_MODE] = s_nxt.status[EV_MODE] | press[K_MODE];
      s_nxt.irq = |(s_nxt.status & s_nxt.mask);
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         s_r <= '0;
         s_r.edState <= ED_VIEW;
         s_r.view <= VW_SEC;
         s_r.nomSet <= NOM_RST;
         s_r.scaleSet <= SCALE_RST;
         s_r.compSet <= COMP_RST;
         s_r.autoMode <= 1'b1;
         s_r.disp.indVolt <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign rdata = s_r.rdata;
   assign irq = s_r.irq;
   assign disp = s_r.disp;
   assign relay = s_r.relay;
   assign nvStore = s_r.nv;

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (sys_rst);

   manual_block_a:
   assert property (!s_r.autoMode |-> !relay.raise && !relay.lower)
      else $error("relay active in manual mode");
   mode_lamp_a:
   assert property (disp.indMode == !s_r.autoMode)
      else $error("mode lamp disagrees with mode");
   alarm_follow_a:
   assert property (##1 relay.underVolt == $past(underVoltIn)
      && relay.highVolt == $past(highVoltIn))
      else $error("alarm relay not following condition");
   pulse_start_a:
   assert property (s_r.autoMode && press[K_MODE] == 1'b0
      && s_r.raiseCnt == '0 && raiseReq |=> relay.raise
      && s_r.raiseCnt == PULSE_W'(PULSE_CYC_P))
      else $error("raise pulse not started");
   pulse_end_a:
   assert property ($fell(relay.raise) && s_r.autoMode
      |-> $past(s_r.raiseCnt) == PULSE_W'(1))
      else $error("raise pulse ended early");
   digit_start_a:
   assert property (s_r.edState == ED_VIEW && press[K_DIGIT]
      && !(|press[K_SCALE:K_SEC]) |=> (s_r.edState == ED_EDIT)
      == editable($past(s_r.view), $past(s_r.optSync[1])))
      else $error("digit key start wrong");
   cursor_step_a:
   assert property (s_r.edState == ED_EDIT && press[K_DIGIT]
      && s_r.cursor != 2'h0 && !(|press[K_SCALE:K_SEC])
      |=> s_r.cursor == $past(s_r.cursor) - 2'h1)
      else $error("cursor did not move right");
   cursor_wrap_a:
   assert property (s_r.edState == ED_EDIT && press[K_DIGIT]
      && s_r.cursor == 2'h0 && !(|press[K_SCALE:K_SEC])
      |=> s_r.cursor == CUR_MSD)
      else $error("cursor did not wrap");
   save_reject_a:
   assert property (s_r.edState == ED_EDIT && press[K_SAVE] && s_r.edited
      && !limitOk(s_r.view, s_r.editVal) && !(|press[K_SCALE:K_SEC])
      |=> !nvStore.write && s_r.edState == ED_EDIT && s_r.cursor == CUR_MSD)
      else $error("bad value not rejected");
   save_return_a:
   assert property (nvStore.write |-> s_r.view == VW_SEC
      && s_r.edState == ED_VIEW && disp.indVolt)
      else $error("save did not return to voltage");
   comp_limit_a:
   assert property (nvStore.write && nvStore.sel == SEL_COMP
      |-> bcd2bin(nvStore.data) <= COMP_MAX)
      else $error("compensation above limit stored");
   primary_lamp_a:
   assert property (s_r.view == VW_PRI |-> disp.indKv && !disp.indVolt)
      else $error("kV lamp missing in primary view");
endmodule
`default_nettype wire

/* sim/kse_keypad_model.sv */
// Operator keypad model: presses one key at a time with contact bounce.
// Assumes the editor samples keys on clk_sys, active high.
`timescale 1ns/100ps
`default_nettype none
module kse_keypad_model (
   input wire logic clk_sys,
   output logic [kse_pkg::NUM_KEYS-1:0] keyPin
);
   import kse_pkg::*;
   initial keyPin = '0;
   // bounce, then a long hold
   // Bounce is shorter than the debounce count, so one action per press
   task automatic press(input int k);
      repeat (2) begin
         @(posedge clk_sys) keyPin[k] <= 1'b1;
         @(posedge clk_sys) keyPin[k] <= 1'b0;
      end
      @(posedge clk_sys) keyPin[k] <= 1'b1;
      repeat (12) @(posedge clk_sys);
      keyPin[k] <= 1'b0;
      repeat (12) @(posedge clk_sys);
      #1;
   endtask
endmodule
`default_nettype wire

/* sim/tb_keypad_setting_editor.sv */
// Self-checking bench for the keypad setting editor.
// Assumes short debounce and pulse counts set at the instance.
`timescale 1ns/100ps
`default_nettype none
module tb_keypad_setting_editor;
   import kse_pkg::*;
   logic clk_sys = 1'b0;
   logic sys_rst = 1'b1;
   logic [NUM_KEYS-1:0] keyPin;
   logic optionPin = 1'b0;
   logic [15:0] secVolt = 16'h04B0;
   logic raiseReq = 1'b0;
   logic lowerReq = 1'b0;
   logic [2:0] alm = 3'h0;
   kse_bus_t bus = '0;
   logic [31:0] rdata;
   logic irq;
   kse_disp_t disp;
   kse_relay_t relay;
   kse_nv_t nvStore;
   kse_nv_t nvLast;
   int errors = 0;
   int checked = 0;
   int nvCnt = 0;
   int n;
   int sv;
   int m;
   logic [31:0] rd;
   always #5 clk_sys = ~clk_sys;
   kse_keypad_model u_kse_keypad_model (.clk_sys(clk_sys), .keyPin(keyPin));
   kse_keypad_editor #(.DEB_CYC(4), .PULSE_CYC_P(16)) u_kse_keypad_editor (
      .clk_sys(clk_sys), .sys_rst(sys_rst), .keyPin(keyPin),
      .optionPin(optionPin), .secVolt(secVolt), .raiseReq(raiseReq),
      .lowerReq(lowerReq), .underVoltIn(alm[2]), .highVoltIn(alm[1]),
      .ctrlFailIn(alm[0]), .bus(bus), .rdata(rdata), .irq(irq),
      .disp(disp), .relay(relay), .nvStore(nvStore));
   // Store writes are single pulses, so count them as they pass
   always @(posedge clk_sys) begin
      if (nvStore.write === 1'b1) begin
         nvCnt++;
         nvLast = nvStore;
      end
   end
   task automatic chk(input string nm, input logic [31:0] s, e);
      checked++;
      if (s !== e) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_sys) bus <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
      @(posedge clk_sys) bus.we <= 1'b0;
   endtask
   task automatic rdr(input logic [3:0] a);
      @(posedge clk_sys) bus <= '{addr: a, wdata: 32'h0, we: 1'b0, re: 1'b1};
      @(posedge clk_sys) bus.re <= 1'b0;
      #1 rd = rdata;
   endtask
   task automatic key(input int k);
      u_kse_keypad_model.press(k);
   endtask
   task automatic tally_and_finish;
      $display("checks %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial begin
      #1_000_000;
      errors++;
      tally_and_finish();
   end
   initial begin
      void'($urandom(10781));
      repeat (12) @(posedge clk_sys);
      sys_rst <= 1'b0;
      @(posedge clk_sys) #1;
      chk("indVolt", disp.indVolt, 1'b1);
      chk("indMode", disp.indMode, 1'b0);
      rdr(REG_STATE);
      chk("auto", rd[7], 1'b1);
      rdr(4'hC);
      chk("unmapped", rd, 32'h0);
      wr(REG_MASK, 32'h7);
      rdr(REG_MASK);
      chk("mask", rd[2:0], 3'h7);
      key(K_DIGIT);
      chk("blink", disp.blink, 4'h0);
      key(K_NOM);
      chk("nom", disp.value, 16'h1100);
      chk("bcd", disp.bcd, 1'b1);
      key(K_DIGIT);
      chk("blink", disp.blink, 4'h8);
      key(K_INC);
      chk("value", disp.value, 16'h2100);
      key(K_SAVE);
      chk("blink", disp.blink, 4'h8);
      chk("nvCnt", nvCnt, 0);
      chk("irq", irq, 1'b1);
      rdr(REG_STATUS);
      chk("status", rd[2:0], 3'h2);
      repeat (2) @(posedge clk_sys);
      #1 chk("irq", irq, 1'b0);
      for (n = 0; n < 4; n++) begin
         key(K_DIGIT);
         chk("cursor", disp.blink, n == 3 ? 4'h8 : 4'h4 >> n);
      end
      repeat (9) key(K_INC);
      chk("wrap", disp.value, 16'h1100);
      key(K_DIGIT);
      key(K_INC);
      key(K_SAVE);
      chk("nvCnt", nvCnt, 1);
      chk("nvData", nvLast.data, 16'h1200);
      chk("nvSel", nvLast.sel, SEL_NOM);
      chk("shown", disp.value, secVolt);
      chk("bcdSec", disp.bcd, 1'b0);
      key(K_NOM);
      key(K_DIGIT);
      key(K_INC);
      key(K_SEC);
      key(K_NOM);
      chk("kept", disp.value, 16'h1200);
      key(K_COMP);
      chk("glyph", disp.glyph, GL_ABSENT);
      @(posedge clk_sys) optionPin <= 1'b1;
      key(K_COMP);
      chk("glyph", disp.glyph, GL_POS);
      chk("indPct", disp.indPct, 1'b1);
      key(K_SIGN);
      chk("glyph", disp.glyph, GL_NEG);
      chk("nvCnt", nvCnt, 1);
      key(K_SAVE);
      chk("nvSign", {nvLast.sel, nvLast.sign}, {SEL_COMP, 1'b1});
      key(K_COMP);
      key(K_DIGIT);
      key(K_INC);
      key(K_SAVE);
      chk("nvCnt", nvCnt, 2);
      chk("blink", disp.blink, 4'h8);
      key(K_SEC);
      sv = 900 + $urandom % 600;
      @(posedge clk_sys) secVolt <= 16'(sv);
      key(K_DEV);
      // Divider may first finish a figure for the old view
      repeat (80) @(posedge clk_sys);
      #1 n = sv > 1200 ? sv - 1200 : 1200 - sv;
      chk("dev", disp.value, n * 1000 / 1200);
      n = sv > 1200 ? GL_POS : sv < 1200 ? GL_NEG : GL_NONE;
      chk("devGlyph", disp.glyph, n);
      chk("indPct", disp.indPct, 1'b1);
      key(K_PRI);
      repeat (80) @(posedge clk_sys);
      #1 chk("pri", disp.value, sv * 220 / 1200);
      chk("indKv", disp.indKv, 1'b1);
      key(K_SEC);
      chk("sec", disp.value, sv);
      key(K_MODE);
      chk("indMode", disp.indMode, 1'b1);
      @(posedge clk_sys) raiseReq <= 1'b1;
      lowerReq <= 1'b1;
      alm <= 3'h7;
      repeat (4) @(posedge clk_sys);
      #1 chk("raise", relay.raise, 1'b0);
      chk("lower", relay.lower, 1'b0);
      chk("alarms", relay[2:0], 3'h7);
      chk("secMan", disp.value, sv);
      @(posedge clk_sys) raiseReq <= 1'b0;
      lowerReq <= 1'b0;
      alm <= 3'h0;
      repeat (2) @(posedge clk_sys);
      #1 chk("alarms", relay[2:0], 3'h0);
      key(K_MODE);
      chk("indMode", disp.indMode, 1'b0);
      @(posedge clk_sys) raiseReq <= 1'b1;
      lowerReq <= 1'b1;
      @(posedge clk_sys) raiseReq <= 1'b0;
      lowerReq <= 1'b0;
      #1 n = 0;
      m = 0;
      repeat (40) begin
         if (relay.raise === 1'b1)
            n++;
         if (relay.lower === 1'b1)
            m++;
         @(posedge clk_sys) #1;
      end
      chk("pulse", n, 16);
      chk("pulseLo", m, 16);
      rdr(REG_STATUS);
      chk("status", rd[2:0], 3'h7);
      tally_and_finish();
   end
endmodule
`default_nettype wire
